// ### hw/flsr_pkg.sv
package flsr_pkg;

  // Register page and offsets on the control port.
  localparam logic [7:0] FLSR_PAGE_ZERO        = 8'h00;
  localparam logic [7:0] FLSR_OFS_GLOBAL_LATCH = 8'h2C;
  localparam logic [7:0] FLSR_OFS_SUMMARY      = 8'h2D;
  localparam logic [7:0] FLSR_OFS_CH_ONE       = 8'h2E;
  localparam logic [7:0] FLSR_OFS_CH_TWO       = 8'h2F;
  localparam logic [7:0] FLSR_OFS_SECOND_LATCH = 8'h36;

  // Reset values of every latch in the block.
  localparam logic [7:0] FLSR_RST_BYTE = 8'h00;
  localparam logic [3:0] FLSR_RST_NIB  = 4'h0;
  localparam logic [1:0] FLSR_RST_PAIR = 2'h0;

  // Global event latch field positions.
  localparam int FLSR_GL_CLK_ERR   = 7;
  localparam int FLSR_GL_PLL_LOCK  = 6;
  localparam int FLSR_GL_OVER_TEMP = 5;
  localparam int FLSR_GL_OVER_CUR  = 4;
  localparam int FLSR_GL_EVT_LSB   = 4;
  localparam int FLSR_GL_EVT_MSB   = 7;

  // Channel summary field positions.
  localparam int FLSR_SUM_CH_ONE   = 7;
  localparam int FLSR_SUM_CH_TWO   = 6;
  localparam int FLSR_SUM_FAR_MSB  = 5;
  localparam int FLSR_SUM_FAR_LSB  = 2;
  localparam int FLSR_SUM_BAT_LOW  = 1;
  localparam int FLSR_SUM_RSVD     = 0;

  // Per-channel bit that is cleared by the second latch read.
  localparam int FLSR_CH_BAT_NEG   = 0;

  // Far channels 3 to 6 carried as 4 bits, channel 3 in bit 3.
  localparam int FLSR_FAR_CH_FIVE  = 1;
  localparam int FLSR_FAR_CH_SIX   = 0;

  // Live detector outputs of one input channel, msb first as latched.
  typedef struct packed {
    logic open_input;
    logic pair_short;
    logic pos_short_gnd;
    logic neg_short_gnd;
    logic pos_short_bias;
    logic neg_short_bias;
    logic pos_short_bat;
    logic neg_short_bat;
  } flsr_chan_live_t;

  // Live global events, msb first as latched.
  typedef struct packed {
    logic clk_error;
    logic pll_lock;
    logic over_temp;
    logic over_current;
  } flsr_global_live_t;

  // Register request from the control-port front end.
  typedef struct packed {
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
  } flsr_bus_req_t;

  // Decoded read strobes.
  typedef struct packed {
    logic global_rd;
    logic summary_rd;
    logic ch_one_rd;
    logic ch_two_rd;
    logic second_rd;
  } flsr_hits_t;

  // True when the request reads the given page-0 offset.
  function automatic logic flsr_addr_hit(flsr_bus_req_t req,
                                         logic [7:0] ofs);
    return req.rd && (req.page == FLSR_PAGE_ZERO) && (req.addr == ofs);
  endfunction

endpackage

// ### hw/flsr_latch_cell.sv
`timescale 1ns/1ps
`default_nettype none

// A vector of self-clearing latched status bits with both clear policies.
module flsr_latch_cell #(
  parameter int W = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] live_in,
  input  wire logic [W-1:0] clr_in,
  input  wire logic         policy_in,
  output logic      [W-1:0] latched_out
);

  typedef struct packed {
    logic [W-1:0] latched;
    logic [W-1:0] live_prev;
  } flsr_cell_state_t;

  flsr_cell_state_t state_reg;
  flsr_cell_state_t state_next;
  logic [W-1:0]     rise;
  logic [W-1:0]     keep_level;
  logic [W-1:0]     keep_edge;

  // Policy 0 holds a bit while its live status is high, so a read cannot
  // drop a fault that is still present; policy 1 drops on every read and
  // sets again only on a fresh rising edge. Set beats clear in both.
  always_comb begin
    rise       = live_in & ~state_reg.live_prev;
    keep_level = state_reg.latched & ~(clr_in & ~live_in);
    keep_edge  = state_reg.latched & ~clr_in;
    state_next = state_reg;
    state_next.live_prev = live_in;
    if (policy_in) begin
      state_next.latched = keep_edge | rise;
    end else begin
      state_next.latched = keep_level | live_in;
    end
  end

  // All latches start empty.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign latched_out = state_reg.latched;

endmodule

`default_nettype wire

// ### hw/flsr_read_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Turns a control-port read into one strobe per register of interest.
module flsr_read_decode (
  input  wire flsr_pkg::flsr_bus_req_t req_in,
  output flsr_pkg::flsr_hits_t         hits_out
);

  // Only page 0 reads count; other pages belong to other blocks.
  always_comb begin
    hits_out.global_rd  = flsr_pkg::flsr_addr_hit(req_in,
                            flsr_pkg::FLSR_OFS_GLOBAL_LATCH);
    hits_out.summary_rd = flsr_pkg::flsr_addr_hit(req_in,
                            flsr_pkg::FLSR_OFS_SUMMARY);
    hits_out.ch_one_rd  = flsr_pkg::flsr_addr_hit(req_in,
                            flsr_pkg::FLSR_OFS_CH_ONE);
    hits_out.ch_two_rd  = flsr_pkg::flsr_addr_hit(req_in,
                            flsr_pkg::FLSR_OFS_CH_TWO);
    hits_out.second_rd  = flsr_pkg::flsr_addr_hit(req_in,
                            flsr_pkg::FLSR_OFS_SECOND_LATCH);
  end

endmodule

`default_nettype wire

// ### hw/flsr_top.sv
`timescale 1ns/1ps
`default_nettype none

module flsr_top (
  input  wire logic                        core_clk_in,
  input  wire logic                        srst_in,
  input  wire flsr_pkg::flsr_bus_req_t     req_in,
  output logic                       [7:0] rdata_out,
  output logic                             rvalid_out,
  input  wire flsr_pkg::flsr_global_live_t global_live_in,
  input  wire flsr_pkg::flsr_chan_live_t   ch_one_live_in,
  input  wire flsr_pkg::flsr_chan_live_t   ch_two_live_in,
  input  wire logic                  [3:0] far_chan_fault_in,
  input  wire logic                        bat_low_short_live_in,
  input  wire logic                        six_channel_variant_in,
  input  wire logic                        clear_policy_select_in,
  input  wire logic                  [7:0] global_event_mask_in,
  input  wire logic                  [7:0] channel_mask_in,
  input  wire logic                  [7:0] fault_type_mask_in,
  output logic                             irq_out
);

  // Registered outputs of this module, kept as one state word.
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } flsr_top_state_t;

  flsr_top_state_t       state_reg;
  flsr_top_state_t       state_next;
  flsr_pkg::flsr_hits_t  hits;
  logic [3:0]            global_live;
  logic [3:0]            global_clr;
  logic [3:0]            global_latched;
  logic [7:0]            ch_one_clr;
  logic [7:0]            ch_two_clr;
  logic [7:0]            ch_one_latched;
  logic [7:0]            ch_two_latched;
  logic                  bat_low_latched;
  logic [7:0]            global_view;
  logic [7:0]            summary_view;
  logic [7:0]            neg_bat_clr;
  logic                  any_global;
  logic                  any_summary;
  logic                  any_fault_type;

  // Read strobes for the four latches and the second fault latch.
  flsr_read_decode u_decode (
    .req_in   (req_in),
    .hits_out (hits)
  );

  // Global event sources in field order.
  assign global_live = {global_live_in.clk_error,
                        global_live_in.pll_lock,
                        global_live_in.over_temp,
                        global_live_in.over_current};
  assign global_clr  = {4{hits.global_rd}};

  flsr_latch_cell #(
    .W (4)
  ) u_global (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .live_in     (global_live),
    .clr_in      (global_clr),
    .policy_in   (clear_policy_select_in),
    .latched_out (global_latched)
  );

  // The negative-pin battery short bit is cleared by the second fault
  // latch read, not by a read of its own register.
  always_comb begin
    neg_bat_clr = flsr_pkg::FLSR_RST_BYTE;
    neg_bat_clr[flsr_pkg::FLSR_CH_BAT_NEG] = hits.second_rd;
  end

  // Own-register reads clear bits 7 to 1 of each channel latch.
  always_comb begin
    ch_one_clr = {8{hits.ch_one_rd}};
    ch_one_clr[flsr_pkg::FLSR_CH_BAT_NEG] = 1'b0;
    ch_one_clr = ch_one_clr | neg_bat_clr;
    ch_two_clr = {8{hits.ch_two_rd}};
    ch_two_clr[flsr_pkg::FLSR_CH_BAT_NEG] = 1'b0;
    ch_two_clr = ch_two_clr | neg_bat_clr;
  end

  // Channel 1 fault latch; the struct order is the bit order.
  flsr_latch_cell #(
    .W (8)
  ) u_ch_one (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .live_in     (ch_one_live_in),
    .clr_in      (ch_one_clr),
    .policy_in   (clear_policy_select_in),
    .latched_out (ch_one_latched)
  );

  // Channel 2 fault latch with the same layout as channel 1.
  flsr_latch_cell #(
    .W (8)
  ) u_ch_two (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .live_in     (ch_two_live_in),
    .clr_in      (ch_two_clr),
    .policy_in   (clear_policy_select_in),
    .latched_out (ch_two_latched)
  );

  // Short to battery while battery sits below bias, any channel.
  flsr_latch_cell #(
    .W (1)
  ) u_bat_low (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .live_in     (bat_low_short_live_in),
    .clr_in      (hits.summary_rd),
    .policy_in   (clear_policy_select_in),
    .latched_out (bat_low_latched)
  );

  // Global latch as software sees it; the low nibble is reserved.
  always_comb begin
    global_view = flsr_pkg::FLSR_RST_BYTE;
    global_view[flsr_pkg::FLSR_GL_EVT_MSB:flsr_pkg::FLSR_GL_EVT_LSB] =
      global_latched;
  end

  // The channel summary bits are derived from the channel latches rather than stored,
  // so they can never disagree with them: a channel's summary bit drops
  // only once its whole latch is clear. Channels 3 to 6 arrive as flags from
  // their own registers; 5 and 6 exist only on the six-channel variant.
  always_comb begin
    summary_view = flsr_pkg::FLSR_RST_BYTE;
    summary_view[flsr_pkg::FLSR_SUM_CH_ONE] = |ch_one_latched;
    summary_view[flsr_pkg::FLSR_SUM_CH_TWO] = |ch_two_latched;
    summary_view[flsr_pkg::FLSR_SUM_FAR_MSB:flsr_pkg::FLSR_SUM_FAR_LSB] =
      far_chan_fault_in;
    if (!six_channel_variant_in) begin
      summary_view[flsr_pkg::FLSR_SUM_FAR_LSB + flsr_pkg::FLSR_FAR_CH_FIVE]
        = 1'b0;
      summary_view[flsr_pkg::FLSR_SUM_FAR_LSB + flsr_pkg::FLSR_FAR_CH_SIX]
        = 1'b0;
    end
    summary_view[flsr_pkg::FLSR_SUM_BAT_LOW] = bat_low_latched;
    summary_view[flsr_pkg::FLSR_SUM_RSVD] = 1'b0;
  end

  // Interrupt terms: a mask bit of 1 blocks its event. Mask registers
  // live elsewhere; their reset to all ones keeps global events quiet
  // until software unmasks them. Fault-type masks apply to the bit of
  // that type in either channel latch held here.
  always_comb begin
    any_global = |(global_view & ~global_event_mask_in);
    any_summary = |(summary_view & ~channel_mask_in);
    any_fault_type = |((ch_one_latched | ch_two_latched)
                       & ~fault_type_mask_in);
  end

  // Read data is the value before the clear takes effect, since the
  // latch and the read sample the same edge. Unknown offsets are not
  // answered here; the front end serves them from other blocks.
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = hits.global_rd | hits.summary_rd |
                        hits.ch_one_rd | hits.ch_two_rd;
    if (hits.global_rd) begin
      state_next.rdata = global_view;
    end else if (hits.summary_rd) begin
      state_next.rdata = summary_view;
    end else if (hits.ch_one_rd) begin
      state_next.rdata = ch_one_latched;
    end else if (hits.ch_two_rd) begin
      state_next.rdata = ch_two_latched;
    end
    state_next.irq = any_global | any_summary | any_fault_type;
  end

  // Synchronous reset puts every output at zero.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_reg.rdata  <= flsr_pkg::FLSR_RST_BYTE;
      state_reg.rvalid <= 1'b0;
      state_reg.irq    <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out  = state_reg.rdata;
  assign rvalid_out = state_reg.rvalid;
  assign irq_out    = state_reg.irq;

endmodule

`default_nettype wire

// ### bench/flsr_top_props.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the fault latch block; it sees only the top's ports.
module flsr_top_props (
  input wire logic                        core_clk_in,
  input wire logic                        srst_in,
  input wire flsr_pkg::flsr_bus_req_t     req_in,
  input wire logic                  [7:0] rdata_out,
  input wire logic                        rvalid_out,
  input wire flsr_pkg::flsr_global_live_t global_live_in,
  input wire flsr_pkg::flsr_chan_live_t   ch_one_live_in,
  input wire flsr_pkg::flsr_chan_live_t   ch_two_live_in,
  input wire logic                  [3:0] far_chan_fault_in,
  input wire logic                        bat_low_short_live_in,
  input wire logic                        six_channel_variant_in,
  input wire logic                        clear_policy_select_in,
  input wire logic                  [7:0] global_event_mask_in,
  input wire logic                  [7:0] channel_mask_in,
  input wire logic                  [7:0] fault_type_mask_in,
  input wire logic                        irq_out
);
  // Page-0 read decode; only 0x2C to 0x2F give an answer.
  logic pg0;
  logic srv;
  logic glr;
  assign pg0 = req_in.rd && (req_in.page == 8'h00);
  assign srv = pg0 && (req_in.addr[7:2] == 6'h0B);
  assign glr = pg0 && (req_in.addr == 8'h2C);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  read_answer_a: assert property (srv |=> rvalid_out)
    else $error("served read gave no answer");
  read_refused_a: assert property (
    !srv |=> !rvalid_out && $stable(rdata_out))
    else $error("answer without a served read");
  global_rsvd_a: assert property (glr |=> rdata_out[3:0] == 4'h0)
    else $error("global reserved bits not zero");
  summary_rsvd_a: assert property (
    (pg0 && req_in.addr == 8'h2D) |=> !rdata_out[0])
    else $error("summary reserved bit not zero");
  reset_zero_a: assert property (disable iff (1'b0)
    srst_in |=> rdata_out == 8'h00 && !rvalid_out && !irq_out)
    else $error("outputs not zero after reset");
  clk_err_a: assert property (
    $rose(global_live_in.clk_error) ##1 glr |=> rdata_out[7])
    else $error("clock error not latched");
  open_input_a: assert property (
    $rose(ch_one_live_in.open_input) ##1
    (pg0 && req_in.addr == 8'h2E) |=> rdata_out[7])
    else $error("open input not latched");
  irq_raise_a: assert property (
    ($rose(global_live_in.over_temp) && !global_event_mask_in[5])
    ##1 !global_event_mask_in[5] |=> irq_out)
    else $error("unmasked event raised no interrupt");
  edge_reread_a: assert property (
    (clear_policy_select_in && glr && $stable(global_live_in)) [*2]
     |=> rdata_out[7:4] == 4'h0)
    else $error("edge policy bit survived a read");

  // Main scenarios reached by the bench.
  cover property (srv ##1 srv);
  cover property (irq_out);
  cover property (clear_policy_select_in && glr);
endmodule

bind flsr_top flsr_top_props i_props (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .req_in(req_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .global_live_in(global_live_in), .ch_one_live_in(ch_one_live_in),
  .ch_two_live_in(ch_two_live_in), .far_chan_fault_in(far_chan_fault_in),
  .bat_low_short_live_in(bat_low_short_live_in),
  .six_channel_variant_in(six_channel_variant_in),
  .clear_policy_select_in(clear_policy_select_in),
  .global_event_mask_in(global_event_mask_in),
  .channel_mask_in(channel_mask_in),
  .fault_type_mask_in(fault_type_mask_in), .irq_out(irq_out));

`default_nettype wire

// ### bench/flsr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the latched fault status block.
module flsr_top_tb;
  logic                        clk;
  logic                        srst;
  flsr_pkg::flsr_bus_req_t     req;
  logic                  [7:0] rdata;
  logic                        rvalid;
  flsr_pkg::flsr_global_live_t gl;
  flsr_pkg::flsr_chan_live_t   c1;
  flsr_pkg::flsr_chan_live_t   c2;
  logic                  [3:0] far;
  logic                        bat;
  logic                        six;
  logic                        pol;
  logic                  [7:0] gm;
  logic                  [7:0] cm;
  logic                  [7:0] fm;
  logic                        irq;
  logic                  [7:0] d;
  logic                 [31:0] seed;
  int                          err_total;
  int                          n_compared;

  flsr_top i_dut (
    .core_clk_in(clk), .srst_in(srst), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .global_live_in(gl), .ch_one_live_in(c1),
    .ch_two_live_in(c2), .far_chan_fault_in(far),
    .bat_low_short_live_in(bat), .six_channel_variant_in(six),
    .clear_policy_select_in(pol), .global_event_mask_in(gm),
    .channel_mask_in(cm), .fault_type_mask_in(fm), .irq_out(irq));

  // 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random source; a fixed start keeps every run the same.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Summary expected after one channel pulse, with far inputs idle.
  function automatic logic [7:0] exp_sum(input int ch, input logic [7:0] v);
    return {(ch == 1) && (v != 8'h00), (ch == 2) && (v != 8'h00), 6'h00};
  endfunction

  // Inputs move 1 ns after the rising edge so every edge sees them settled.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A one-cycle read, then an idle cycle so the strobe is never reused.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    req = '{1'b1, 8'h00, a};
    tick();
    q = rdata;
    chk("rvalid", {7'h00, rvalid}, {7'h00, a[7:2] == 6'h0B});
    req.rd = 1'b0;
    tick();
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] exp);
    rd(a, d);
    chk(nm, d, exp);
  endtask

  // Pulse one channel, read summary and channel, then clear bit 0.
  task automatic chan_case(input int ch, input logic [7:0] v);
    logic [7:0] a_ch;
    a_ch = 8'h2D + 8'(ch);
    if (ch == 1) c1 = v;
    else c2 = v;
    tick();
    c1 = '0;
    c2 = '0;
    rc("summary", 8'h2D, exp_sum(ch, v));
    rc("channel", a_ch, v);
    rc("chan kept", a_ch, v & 8'h01);
    rd(8'h36, d);
    rc("chan bit0", a_ch, 8'h00);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    err_total = 0;
    n_compared = 0;
    req = '0;
    gl = '0;
    c1 = '0;
    c2 = '0;
    {far, bat, six, pol} = 7'h00;
    {gm, cm, fm} = 24'hFFFFFF;
    seed = 32'hE093;
    srst = 1'b1;
    repeat (6) tick();
    srst = 1'b0;
    for (int a = 8'h2C; a <= 8'h2F; a++) rc("reset", 8'(a), 8'h00);
    rc("unmapped", 8'h30, 8'h00);
    $display("test reset done");
    for (int b = 4; b < 8; b++) begin
      gl = 4'h1 << (b - 4);
      tick();
      gl = '0;
      rc("global", 8'h2C, 8'h01 << b);
      rc("global clr", 8'h2C, 8'h00);
    end
    $display("test global done");
    for (int i = 0; i < 16; i++) chan_case(1 + i / 8, 8'h01 << (i % 8));
    repeat (6) begin
      seed = lfsr(seed);
      chan_case(1 + seed[8], seed[7:0]);
    end
    $display("test channel done");
    far = 4'hF;
    rc("far", 8'h2D, 8'h30);
    six = 1'b1;
    rc("six", 8'h2D, 8'h3C);
    far = 4'h0;
    bat = 1'b1;
    tick();
    bat = 1'b0;
    rc("battery", 8'h2D, 8'h02);
    rc("battery clr", 8'h2D, 8'h00);
    $display("test summary done");
    gl.clk_error = 1'b1;
    tick();
    rc("level hold", 8'h2C, 8'h80);
    rc("level hold", 8'h2C, 8'h80);
    pol = 1'b1;
    req = '{1'b1, 8'h00, 8'h2C};
    tick();
    chk("edge first", rdata, 8'h80);
    tick();
    req.rd = 1'b0;
    chk("edge second", rdata, 8'h00);
    gl = '0;
    tick();
    gl.clk_error = 1'b1;
    tick();
    rc("edge rise", 8'h2C, 8'h80);
    gl = '0;
    pol = 1'b0;
    $display("test policy done");
    chk("irq idle", {7'h00, irq}, 8'h00);
    gm = 8'h5F;
    gl = 4'hA;
    tick();
    gl = '0;
    tick();
    chk("irq set", {7'h00, irq}, 8'h01);
    rc("irq source", 8'h2C, 8'hA0);
    chk("irq clr", {7'h00, irq}, 8'h00);
    gm = 8'hFF;
    gl.over_current = 1'b1;
    tick();
    gl = '0;
    tick();
    chk("irq masked", {7'h00, irq}, 8'h00);
    rc("masked src", 8'h2C, 8'h10);
    cm = 8'h7F;
    fm = 8'h00;
    c1.pair_short = 1'b1;
    tick();
    c1 = '0;
    tick();
    chk("irq chan", {7'h00, irq}, 8'h01);
    rc("chan src", 8'h2E, 8'h40);
    chk("irq chan clr", {7'h00, irq}, 8'h00);
    $display("test interrupt done");
    print_verdict();
  end
endmodule

`default_nettype wire
